// >>> bench/jtp_host.sv
// debugger model driving the scan clock, mode and data pins
module jtp_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input  logic tdo_o,
  input  logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic o;
  // a released line reads high through its pull-up
  wire  tdo_w = tdo_oe_n ? 1'b1 : tdo_o;
  initial {tck, tms, tdi} = 3'h7;
  task automatic cyc(input logic m, input logic d);
    tck = 1'b0;
    {tms, tdi} = {m, d};
    #200 tck = 1'b1;
    o = tdo_w;
    #200;
  endtask
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    cyc(1'b1, 1'b1);
    if (ir) cyc(1'b1, 1'b1);
    repeat (2) cyc(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i]);
      dout[i] = o;
    end
    cyc(1'b1, 1'b1);
    cyc(1'b0, 1'b1);
  endtask
  task automatic sw(input logic [15:0] p);
    repeat (50) cyc(1'b1, 1'b1);
    for (int i = 0; i < 16; i++) cyc(p[i], 1'b1);
  endtask
endmodule  // jtp_host

// >>> bench/jtp_tap_properties.sv
// concurrent checks on the test access port ports
module jtp_tap_chk (
  input logic       mclk,
  input logic       reset_n,
  input logic       ext_reset_n,
  input logic       tck,
  input logic       trst_n,
  input logic       tdo_oe_n,
  input logic       pin_alt_function_we,
  input logic [4:0] pin_alt_function_select_q,
  input logic       pin_config_unlocked_q,
  input logic       mass_erase_q,
  input logic       nv_restore_q,
  input logic [3:0] ir_q,
  input logic [3:0] tap_state_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  stop_hold_a: assert property (($stable(tck) && trst_n) [*5] |-> $stable(tap_state_q))
    else $error("state moved with tck still");
  trst_hold_a: assert property (!trst_n [*5] |-> tap_state_q == 4'h0)
    else $error("trst low outside reset state");
  tlr_ir_a: assert property (tap_state_q == 4'h0 |=> ir_q == 4'he)
    else $error("reset state without id instruction");
  oe_idle_a: assert property ((tap_state_q == 4'h0) [*4] |-> tdo_oe_n)
    else $error("tdo driven while idle");
  alt_guard_a: assert property (pin_alt_function_we && !pin_config_unlocked_q && ext_reset_n
    |=> $stable(pin_alt_function_select_q)) else $error("locked alternate bits changed");
  ext_pins_a: assert property (!ext_reset_n |=> pin_alt_function_select_q == 5'h1f)
    else $error("pins not debug after reset");
  erase_len_a: assert property ($rose(mass_erase_q) |-> mass_erase_q [*8])
    else $error("erase too short");
  restore_a: assert property ($fell(mass_erase_q) |-> ##[0:2] nv_restore_q)
    else $error("no restore after erase");
  cover property (mass_erase_q);
  cover property (pin_config_unlocked_q);
  cover property (!trst_n [*5]);
endmodule  // jtp_tap_chk

// >>> bench/jtp_tap_tb.sv
// self-checking bench for the test access port with debug pin lock
`include "jtp_consts.vh"
module jtp_tap_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID_VAL = 32'h5a5bc0d1;  // arbitrary value
  logic        mclk, reset_n, ext_reset_n, trst_n, tck, tms, tdi, tdo_o, tdo_oe_n, dbg_done;
  logic        pin_alt_function_we, pin_config_lock_we, pin_config_commit_we, dbg_req_q;
  logic        pin_config_unlocked_q, mass_erase_q, nv_restore_q;
  logic [4:0]  pin_alt_function_wdata, pin_config_commit_wdata, pin_digital_enable_q;
  logic [4:0]  pin_pullup_select_q, pin_alt_function_select_q;
  logic [31:0] pin_config_lock_wdata, dbg_rdata;
  logic [3:0]  ir_q, tap_state_q;
  logic [34:0] dbg_cmd_q, cmd, seen;
  logic [63:0] got;
  logic [15:0] lfsr_q = 16'hac45;
  int          err_total, n_tests;
  jtp_tap #(.ID_VALUE(ID_VAL)) dut (.*);
  jtp_host host (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) if (dbg_req_q === 1'b1) seen <= dbg_cmd_q;
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function automatic logic [63:0] exp8(input logic [3:0] c, input logic [7:0] d);
    return (c == `JTP_IR_IDCODE) ? ID_VAL[7:0] : {d[6:0], 1'b0};
  endfunction
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input int k, input logic [31:0] v);
    tick();
    {pin_alt_function_wdata, pin_config_lock_wdata, pin_config_commit_wdata} = {v[4:0], v, v[4:0]};
    {pin_alt_function_we, pin_config_lock_we, pin_config_commit_we} = {k == 0, k == 1, k == 2};
    tick();
    {pin_alt_function_we, pin_config_lock_we, pin_config_commit_we} = 3'h0;
  endtask
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {reset_n, ext_reset_n, trst_n, dbg_done, dbg_rdata, err_total, n_tests} = '0;
    {pin_alt_function_we, pin_config_lock_we, pin_config_commit_we} = 3'h0;
    {pin_alt_function_wdata, pin_config_lock_wdata, pin_config_commit_wdata} = '0;
    repeat (20) @(posedge mclk);
    #2 {reset_n, ext_reset_n, trst_n} = 3'h7;
    repeat (4) tick();
    chk({pin_digital_enable_q, pin_pullup_select_q, pin_alt_function_select_q}, 15'h7fff);
    chk({tap_state_q, ir_q, tdo_oe_n}, 9'h01d);
    repeat (5) host.cyc(1'b1, 1'b1);
    host.cyc(1'b0, 1'b1);
    host.scan(1'b0, 32, 64'h0, got);
    chk(got, ID_VAL);
    for (int i = 0; i < 12; i++) begin
      logic [3:0]  c;
      logic [11:0] d;
      {d, c} = rnd();
      if (i == 0) c = 4'h0;
      if (c inside {4'h8, 4'ha, 4'hb}) c = `JTP_IR_BYPASS;
      host.scan(1'b1, 4, c, got);
      chk(got, 64'h1);
      chk(ir_q, c);
      host.scan(1'b0, 8, d, got);
      chk(got, exp8(c, d[7:0]));
    end
    host.scan(1'b1, 4, `JTP_IR_DBG_DP, got);
    got = {rnd(), rnd(), rnd(), rnd()};
    cmd = got[34:0];
    host.scan(1'b0, 35, cmd, got);
    chk(got[2:0], `JTP_ACK_OK);
    chk(seen, cmd);
    host.scan(1'b0, 35, cmd, got);
    chk(got[2:0], `JTP_ACK_WAIT);
    tick();
    {dbg_done, dbg_rdata} = {1'b1, rnd(), rnd()};
    tick();
    dbg_done = 1'b0;
    host.scan(1'b0, 35, cmd, got);
    chk(got[34:0], {dbg_rdata, `JTP_ACK_OK});
    wr(0, 0);
    chk(pin_alt_function_select_q, 5'h1f);
    wr(1, `JTP_UNLOCK_KEY);
    chk(pin_config_unlocked_q, 1'b1);
    wr(2, 32'h3);
    wr(0, 0);
    chk(pin_alt_function_select_q, 5'h1c);
    wr(1, 32'h0);
    chk(pin_config_unlocked_q, 1'b0);
    wr(0, 32'h1f);
    chk(pin_alt_function_select_q, 5'h1c);
    host.scan(1'b1, 4, `JTP_IR_BYPASS, got);
    repeat (5) host.cyc(1'b1, 1'b1);
    chk({tap_state_q, ir_q}, 8'h0e);
    host.cyc(1'b0, 1'b1);
    host.scan(1'b1, 4, `JTP_IR_BYPASS, got);
    chk(ir_q, `JTP_IR_BYPASS);
    tick();
    trst_n = 1'b0;
    repeat (6) tick();
    chk({tap_state_q, ir_q}, 8'h0e);
    trst_n = 1'b1;
    ext_reset_n = 1'b0;
    repeat (2) tick();
    chk(pin_alt_function_select_q, 5'h1f);
    for (int i = 0; i < 10; i++) begin
      host.sw(i[0] ? `JTP_SW_TO_JTAG : `JTP_SW_TO_SWD);
      if (i == 8) chk(mass_erase_q, 1'b0);
    end
    for (int k = 0; k < 40 && mass_erase_q !== 1'b1; k++) tick();
    chk(mass_erase_q, 1'b1);
    for (int k = 0; k < 40 && nv_restore_q !== 1'b1; k++) tick();
    chk(nv_restore_q, 1'b1);
    ext_reset_n = 1'b1;
    give_verdict();
  end
  initial begin
    #1_000_000;
    err_total++;
    give_verdict();
  end
endmodule  // jtp_tap_tb
bind jtp_tap jtp_tap_chk chk (.*);

// >>> common/jtp_consts.vh
// constants for the test access port with debug pin lock
`ifndef JTP_CONSTS_VH
`define JTP_CONSTS_VH
`define JTP_IR_W          4
`define JTP_IR_IDCODE     4'he
`define JTP_IR_BYPASS     4'hf
`define JTP_IR_DBG_DP     4'ha
`define JTP_IR_DBG_AP     4'hb
`define JTP_IR_ABORT      4'h8
`define JTP_IR_CAPTURE    4'h1
`define JTP_ACK_OK        3'h2
`define JTP_ACK_WAIT      3'h1
`define JTP_DBG_W         35
`define JTP_PINS          5
`define JTP_PIN_RESET     5'h1f
`define JTP_UNLOCK_KEY    32'h4c4f434b
`define JTP_SW_TO_SWD     16'he79e
`define JTP_SW_TO_JTAG    16'he73c
`define JTP_SWITCH_COUNT  4'ha
`define JTP_ONES_MIN      6'h32
`define JTP_ERASE_CYC     8'h10
`endif

// >>> design/jtp_sync.v
// two-flop synchroniser for a bundle of pin inputs
module jtp_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         reset_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // jtp_sync

// >>> design/jtp_tap.v
// test access port, debug pin lock and recovery detector
// Summary of operation
// - stopped tck leaves state and chains unchanged while trst is high
// - tms sampled each rising tck steers state
// - five tms-high clocks reach test-logic-reset
// - test-logic-reset loads identification instruction
// - tdi sampled rising tck into selected chain
// - tdo changes on falling tck
// - tdo released unless shifting
// - power-on reset or trst forces reset state
// - capture loads chain, shift moves one bit
// - update copies shifted value to holding register, debug only when ack is ok
// - debug pins reset to enable, pullup, alternate
// - cleared alternate bits give pins to gpio
// - alternate writes need unlock and commit bits
// - ten switches in reset trigger erase first
// - debug capture returns result plus three-bit ack
// - trst low holds test-logic-reset
// - four-bit ir, 1110 id, 1010/1011 debug, 1111/others bypass
`include "jtp_consts.vh"
module jtp_tap #(
  parameter [31:0] ID_VALUE = 32'h00000001  // arbitrary identification value
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        ext_reset_n,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  input  wire        trst_n,
  output reg         tdo_o,
  output reg         tdo_oe_n,
  input  wire [4:0]  pin_alt_function_wdata,
  input  wire        pin_alt_function_we,
  input  wire [31:0] pin_config_lock_wdata,
  input  wire        pin_config_lock_we,
  input  wire [4:0]  pin_config_commit_wdata,
  input  wire        pin_config_commit_we,
  output reg  [4:0]  pin_digital_enable_q,
  output reg  [4:0]  pin_pullup_select_q,
  output reg  [4:0]  pin_alt_function_select_q,
  output reg         pin_config_unlocked_q,
  output reg         mass_erase_q,
  output reg         nv_restore_q,
  input  wire        dbg_done,
  input  wire [31:0] dbg_rdata,
  output reg         dbg_req_q,
  output reg  [34:0] dbg_cmd_q,
  output reg  [3:0]  ir_q,
  output reg  [3:0]  tap_state_q
);
  localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3,
                   S_SHDR = 4'h4, S_E1DR = 4'h5, S_PDR = 4'h6, S_E2DR = 4'h7,
                   S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'ha, S_SHIR = 4'hb,
                   S_E1IR = 4'hc, S_PIR = 4'hd, S_E2IR = 4'he, S_UIR = 4'hf;

  wire [3:0] pins_s;
  jtp_sync #(.W(4)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .d       ({tck, tms, tdi, trst_n}),
    .q       (pins_s)
  );
  wire tck_s  = pins_s[3];
  wire tms_s  = pins_s[2];
  wire tdi_s  = pins_s[1];
  wire trst_s = pins_s[0];

  reg         tck_d1_q;
  reg  [3:0]  state_d;
  reg  [3:0]  ir_sh_q;
  reg  [34:0] dr_sh_q;
  reg  [2:0]  ack_q;
  reg  [31:0] dbg_res_q;
  // edges seen only when tck actually toggles; a stopped clock holds state and chains unless trst is low
  wire rise = tck_s & ~tck_d1_q;
  wire fall = ~tck_s & tck_d1_q;
  wire is_dbg = (ir_q == `JTP_IR_DBG_DP) || (ir_q == `JTP_IR_DBG_AP);
  wire is_id  = (ir_q == `JTP_IR_IDCODE);

  always @* begin
    case (tap_state_q)
      S_TLR:  state_d = tms_s ? S_TLR  : S_RTI;
      S_RTI:  state_d = tms_s ? S_SDR  : S_RTI;
      S_SDR:  state_d = tms_s ? S_SIR  : S_CDR;
      S_CDR:  state_d = tms_s ? S_E1DR : S_SHDR;
      S_SHDR: state_d = tms_s ? S_E1DR : S_SHDR;
      S_E1DR: state_d = tms_s ? S_UDR  : S_PDR;
      S_PDR:  state_d = tms_s ? S_E2DR : S_PDR;
      S_E2DR: state_d = tms_s ? S_UDR  : S_SHDR;
      S_UDR:  state_d = tms_s ? S_SDR  : S_RTI;
      S_SIR:  state_d = tms_s ? S_TLR  : S_CIR;
      S_CIR:  state_d = tms_s ? S_E1IR : S_SHIR;
      S_SHIR: state_d = tms_s ? S_E1IR : S_SHIR;
      S_E1IR: state_d = tms_s ? S_UIR  : S_PIR;
      S_PIR:  state_d = tms_s ? S_E2IR : S_PIR;
      S_E2IR: state_d = tms_s ? S_UIR  : S_SHIR;
      S_UIR:  state_d = tms_s ? S_SDR  : S_RTI;
      default: state_d = S_TLR;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tck_d1_q    <= 1'b1;
      tap_state_q <= S_TLR;
      ir_q        <= `JTP_IR_IDCODE;
      ir_sh_q     <= 4'h0;
      dr_sh_q     <= 35'h0;
      dbg_req_q   <= 1'b0;
      dbg_cmd_q   <= 35'h0;
      ack_q       <= `JTP_ACK_OK;
      dbg_res_q   <= 32'h0;
      tdo_o       <= 1'b1;
      tdo_oe_n    <= 1'b1;
    end else begin
      tck_d1_q  <= tck_s;
      dbg_req_q <= 1'b0;
      if (dbg_done) begin
        ack_q     <= `JTP_ACK_OK;
        dbg_res_q <= dbg_rdata;
      end
      if (!trst_s) begin
        tap_state_q <= S_TLR;
        ir_q        <= `JTP_IR_IDCODE;
        tdo_oe_n    <= 1'b1;
      end else if (rise) begin
        tap_state_q <= state_d;
        if (state_d == S_TLR)
          ir_q <= `JTP_IR_IDCODE;
        case (tap_state_q)
          S_CIR:  ir_sh_q <= 4'h1;
          S_SHIR: ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
          S_UIR:  ir_q    <= ir_sh_q;
          S_CDR: begin
            if (is_dbg)
              dr_sh_q <= {dbg_res_q, ack_q};
            else if (is_id)
              dr_sh_q <= {3'h0, ID_VALUE};
            else
              dr_sh_q <= 35'h0;
          end
          S_SHDR: begin
            if (is_dbg)
              dr_sh_q <= {tdi_s, dr_sh_q[34:1]};
            else if (is_id)
              dr_sh_q <= {3'h0, tdi_s, dr_sh_q[31:1]};
            else
              dr_sh_q <= {34'h0, tdi_s};
          end
          S_UDR: begin
            if (is_dbg && ack_q == `JTP_ACK_OK) begin
              dbg_cmd_q <= dr_sh_q;
              dbg_req_q <= 1'b1;
              ack_q     <= `JTP_ACK_WAIT;
            end
          end
          default: ;
        endcase
      end else if (fall) begin
        // tdo driven only in shift states, changed on the falling edge
        tdo_oe_n <= ~((tap_state_q == S_SHIR) || (tap_state_q == S_SHDR));
        tdo_o    <= (tap_state_q == S_SHIR) ? ir_sh_q[0] : dr_sh_q[0];
      end
    end
  end

  // debug pin configuration, reset by power-on or external reset
  reg [4:0] commit_q;
  reg [4:0] pin_alt_d;
  always @* begin
    pin_alt_d = pin_alt_function_select_q;
    if (pin_alt_function_we && pin_config_unlocked_q)
      pin_alt_d = (pin_alt_function_wdata & commit_q) |
                  (pin_alt_function_select_q & ~commit_q);
  end
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_digital_enable_q      <= `JTP_PIN_RESET;
      pin_pullup_select_q       <= `JTP_PIN_RESET;
      pin_alt_function_select_q <= `JTP_PIN_RESET;
      pin_config_unlocked_q     <= 1'b0;
      commit_q                  <= 5'h0;
    end else if (!ext_reset_n) begin
      pin_digital_enable_q      <= `JTP_PIN_RESET;
      pin_pullup_select_q       <= `JTP_PIN_RESET;
      pin_alt_function_select_q <= `JTP_PIN_RESET;
      pin_config_unlocked_q     <= 1'b0;
      commit_q                  <= 5'h0;
    end else begin
      // a zero here hands the pin to gpio control
      pin_alt_function_select_q <= pin_alt_d;
      if (pin_config_lock_we)
        pin_config_unlocked_q <= (pin_config_lock_wdata == `JTP_UNLOCK_KEY);
      if (pin_config_commit_we && pin_config_unlocked_q)
        commit_q <= pin_config_commit_wdata;
    end
  end

  // recovery: count switch patterns on tms while external reset is held
  reg [15:0] tms_hist_q;
  reg [5:0]  ones_q;
  reg        armed_q;
  reg [3:0]  switch_cnt_q;
  reg [7:0]  erase_cnt_q;
  wire [15:0] hist_d = {tms_s, tms_hist_q[15:1]};
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tms_hist_q   <= 16'h0;
      ones_q       <= 6'h0;
      armed_q      <= 1'b0;
      switch_cnt_q <= 4'h0;
      erase_cnt_q  <= 8'h0;
      mass_erase_q <= 1'b0;
      nv_restore_q <= 1'b0;
    end else begin
      nv_restore_q <= 1'b0;
      if (mass_erase_q) begin
        // erase runs first, then the nonvolatile restore pulse
        if (erase_cnt_q == `JTP_ERASE_CYC) begin
          mass_erase_q <= 1'b0;
          nv_restore_q <= 1'b1;
        end
        erase_cnt_q <= erase_cnt_q + 8'h01;
      end else if (ext_reset_n) begin
        switch_cnt_q <= 4'h0;
        armed_q      <= 1'b0;
        ones_q       <= 6'h0;
      end else if (rise) begin
        tms_hist_q <= hist_d;
        if (tms_s) begin
          if (ones_q != `JTP_ONES_MIN)
            ones_q <= ones_q + 6'h01;
          // the fiftieth high clock arms the pattern match
          if (ones_q >= `JTP_ONES_MIN - 6'h01)
            armed_q <= 1'b1;
        end else begin
          ones_q <= 6'h0;
        end
        if (armed_q && (hist_d == `JTP_SW_TO_SWD || hist_d == `JTP_SW_TO_JTAG)) begin
          armed_q <= 1'b0;
          ones_q  <= 6'h0;
          if (switch_cnt_q == `JTP_SWITCH_COUNT - 4'h1) begin
            mass_erase_q <= 1'b1;
            erase_cnt_q  <= 8'h0;
            switch_cnt_q <= 4'h0;
          end else begin
            switch_cnt_q <= switch_cnt_q + 4'h1;
          end
        end
      end
    end
  end
endmodule // jtp_tap
